/* scs_pkg.sv */
// Constants, types and field layout of the SONET clock and section alarm registers
//------------------------------------------------------------
// What this block does
// RL1: Diagnostic loopback bit routes transmit into receive
// RL2: Software never sets both loopback bits together
// RL3: Loop timing off: transmit clocked from transmit reference
// RL4: Loop timing on: receive reference or recovered clock
// RL5: Transmit out-of-lock bit shows synthesizer deviation
// RL6: Transmit lock change interrupts when enabled
// RL7: Select 0: 19.44 MHz reference, times 8 or 8/3
// RL8: Select 1: 6.48 MHz reference, times 24 or 8
// RL9: Transmit select ignored while transmit bypass high
// RL10: Receive out-of-lock: deviation or 80 quiet bits
// RL11: Receive lock change interrupts when enabled
// RL12: Receive select picks reference and recovered divider
// RL13: Receive select ignored while receive bypass high
// RL14: Descramble-disable bit bypasses receive descrambling
// RL15: Force bit declares out of frame next boundary
// RL16: Enabled parity errors pull interrupt low
// RL17: Enabled signal, frame, slip alarms pull interrupt
// RL18: Parity event bit 6, cleared by status read
// RL19: Bits 5,4,3 flag state changes, read clears
// RL20: Live signal loss bit follows receive processor
// RL21: Frame loss after 3 ms slip, held 3 ms
// RL22: Interrupt released once enabled events are cleared
//------------------------------------------------------------
package scs_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_LOOP_CTRL = 6'h05;
   localparam logic [5:0] IDX_TX_SYNTH  = 6'h06;
   localparam logic [5:0] IDX_RX_SYNTH  = 6'h07;
   localparam logic [5:0] IDX_RSO_CTRL  = 6'h10;
   localparam logic [5:0] IDX_RSO_STAT  = 6'h11;
   // Field positions
   localparam int B_LOOP_TIMING = 0;
   localparam int B_DIAG    = 1;
   localparam int B_LINE    = 2;
   localparam int B_REFSEL  = 0;
   localparam int B_OOL_EN  = 1;
   localparam int B_OOL     = 3;
   localparam int B_SLIP_EN = 0;
   localparam int B_LOF_EN  = 1;
   localparam int B_LOS_EN  = 2;
   localparam int B_PAR_EN  = 3;
   localparam int B_FORCE   = 5;
   localparam int B_DESCR   = 6;
   localparam int B_PAR_EV  = 6;
   // Event vector positions, bits 0..3 match status bits 3..6
   localparam int EV_SLIP = 0;
   localparam int EV_LOF  = 1;
   localparam int EV_LOS  = 2;
   localparam int EV_PAR  = 3;
   localparam int EV_TX   = 4;
   localparam int EV_RX   = 5;
   localparam int NUM_EV  = 6;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // Timing
   localparam int CLK_MHZ      = 125;
   localparam int LOF_TIME_US  = 3000;
   localparam int LOF_CYCLES   = LOF_TIME_US * CLK_MHZ;
   localparam int QUIET_BITS   = 80;
   // Clock ratio codes for multiplier and divider
   typedef enum logic [1:0] {
      RATIO_8_3  = 2'h0,
      RATIO_8    = 2'h1,
      RATIO_24   = 2'h2,
      RATIO_BYP  = 2'h3
   } scs_ratio_type;
   // Transmit clock source
   typedef enum logic [1:0] {
      SRC_TX_REF = 2'h0,
      SRC_RX_REF = 2'h1,
      SRC_RECOV  = 2'h2
   } scs_src_type;
   // Frame loss tracker, Gray along the path
   typedef enum logic [1:0] {
      ST_INF = 2'h0,
      ST_OOF = 2'h1,
      ST_LOF = 2'h3,
      ST_REC = 2'h2
   } scs_state_type;
endpackage

/* scs_regs.sv */
// Register bank and alarm logic of the SONET clock and section alarm block
//
// Implementation choice: the Wishbone register port.
module scs_regs
   import scs_pkg::*;
#(
   parameter int LOF_COUNT = LOF_CYCLES
)(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Wishbone classic slave
   input  wire logic       wb_cyc_i,
   input  wire logic       wb_stb_i,
   input  wire logic       wb_we_i,
   input  wire logic [7:0] wb_adr_i,
   input  wire logic [3:0] wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]     wb_dat_o,
   output logic            wb_ack_o,
   // Pins and clock monitors
   input  wire logic       tx_bypass_pin,
   input  wire logic       rx_bypass_pin,
   input  wire logic       line_rate_select_pin,
   input  wire logic       cdr_active_in,
   input  wire logic       tx_freq_off_in,
   input  wire logic       rx_freq_off_in,
   input  wire logic       rx_bit_tick_in,
   input  wire logic       rx_data_edge_in,
   // Receive section processor
   input  wire logic       signal_loss_in,
   input  wire logic       frame_slip_in,
   input  wire logic       section_parity_err_in,
   input  wire logic       frame_boundary_in,
   // Datapath controls
   output logic            diag_loopback_enable,
   output logic            line_loopback_enable,
   output logic [1:0]      tx_clk_source,
   output logic [1:0]      tx_pll_ratio,
   output logic [1:0]      rx_div_ratio,
   output logic            descramble_disable,
   output logic            force_frame_loss,
   // Interrupt
   output logic            interrupt_out_n
);
   //------------------------------------------------------------
   // Elaboration checks
   //------------------------------------------------------------
   localparam int CW = $clog2(LOF_COUNT + 1);
   generate
      if (LOF_COUNT < 1) begin : g_bad
         $error("LOF_COUNT must be at least one");
      end
   endgenerate

   //------------------------------------------------------------
   // Declarations
   //------------------------------------------------------------
   logic            req;              // Access taken this edge
   logic            wr;               // Write with low lane
   logic            rd;               // Read access
   logic [5:0]      idx;              // Register index
   logic            ack_q;            // Bus answer
   logic [31:0]     dat_q;            // Read data
   logic            loop_timing_q;    // Loop timing enable
   logic            diag_q;           // Diagnostic loopback
   logic            line_q;           // Line loopback
   logic            tx_sel_q;         // Transmit reference select
   logic            rx_sel_q;         // Receive reference select
   logic [NUM_EV-1:0] en_q;           // Event enables
   logic            descr_q;          // Descramble disable
   logic            force_pend_q;     // Force waiting for boundary
   logic            force_q;          // Force pulse to processor
   logic            tx_ool_q;         // Transmit out of lock
   logic            rx_ool_q;         // Receive out of lock
   logic [6:0]      quiet_q;          // Bits without transition
   scs_state_type   st_q;             // Frame loss tracker
   scs_state_type   st_d;
   logic [CW-1:0]   cnt_q;            // Frame loss timer
   logic            lof;              // Frame loss state
   logic            los_q;            // Previous states
   logic            lof_q;
   logic            slip_q;
   logic [NUM_EV-1:0] ev_set;         // Event causes
   logic [NUM_EV-1:0] ev_clr;         // Read clears
   logic [NUM_EV-1:0] ev_q;           // Sticky events
   logic [1:0]      tx_src_q;
   logic [1:0]      tx_ratio_q;
   logic [1:0]      rx_ratio_q;
   logic            irq_n_q;

   //------------------------------------------------------------
   // Bus decode
   //------------------------------------------------------------
   assign req = wb_cyc_i & wb_stb_i & ~ack_q;
   // Write lands at the edge where the master samples ack high
   assign wr  = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0];
   assign rd  = req & ~wb_we_i;
   assign idx = wb_adr_i[7:2];

   // Answer one cycle after the strobe, drop next cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) ack_q <= 1'b0;
      else     ack_q <= req;
   end

   // Read mux, unmapped reads return zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dat_q <= '0;
      end else if (rd) begin
         dat_q <= '0;
         unique case (idx)
            IDX_LOOP_CTRL: begin
               dat_q[B_LOOP_TIMING] <= loop_timing_q;
               dat_q[B_DIAG]  <= diag_q;
               dat_q[B_LINE]  <= line_q;
            end
            IDX_TX_SYNTH: begin
               dat_q[B_REFSEL] <= tx_sel_q;
               dat_q[B_OOL_EN] <= en_q[EV_TX];
               dat_q[B_OOL]    <= tx_ool_q; // see RL5
            end
            IDX_RX_SYNTH: begin
               dat_q[B_REFSEL] <= rx_sel_q;
               dat_q[B_OOL_EN] <= en_q[EV_RX];
               dat_q[B_OOL]    <= rx_ool_q; // see RL10
            end
            IDX_RSO_CTRL: begin
               dat_q[B_DESCR]  <= descr_q;
               dat_q[3:0]      <= en_q[EV_PAR:EV_SLIP];
            end
            IDX_RSO_STAT: begin
               dat_q[6:3] <= ev_q[EV_PAR:EV_SLIP]; // see RL18
               dat_q[2]   <= los_q; // see RL20
               dat_q[1]   <= lof_q;
               dat_q[0]   <= slip_q;
            end
            default: dat_q <= '0;
         endcase
      end
   end

   //------------------------------------------------------------
   // Writable controls
   //------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         loop_timing_q <= 1'b0;
         diag_q   <= 1'b0;
         line_q   <= 1'b0;
         tx_sel_q <= 1'b0;
         rx_sel_q <= 1'b0;
         en_q     <= '0;
         descr_q  <= 1'b0;
      end else if (wr) begin
         if (idx == IDX_LOOP_CTRL) begin
            loop_timing_q <= wb_dat_i[B_LOOP_TIMING];
            diag_q  <= wb_dat_i[B_DIAG];
            line_q  <= wb_dat_i[B_LINE];
         end
         if (idx == IDX_TX_SYNTH) begin
            tx_sel_q     <= wb_dat_i[B_REFSEL];
            en_q[EV_TX]  <= wb_dat_i[B_OOL_EN];
         end
         if (idx == IDX_RX_SYNTH) begin
            rx_sel_q     <= wb_dat_i[B_REFSEL];
            en_q[EV_RX]  <= wb_dat_i[B_OOL_EN];
         end
         if (idx == IDX_RSO_CTRL) begin
            descr_q <= wb_dat_i[B_DESCR]; // see RL14
            en_q[EV_PAR:EV_SLIP] <= wb_dat_i[3:0];
         end
      end
   end

   // Write-only force: held until the next frame boundary
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         force_pend_q <= 1'b0;
         force_q      <= 1'b0;
      end else begin
         force_q <= force_pend_q & frame_boundary_in; // see RL15
         if (wr && idx == IDX_RSO_CTRL && wb_dat_i[B_FORCE])
            force_pend_q <= 1'b1;
         else if (frame_boundary_in)
            force_pend_q <= 1'b0;
      end
   end

   //------------------------------------------------------------
   // Clock selection
   //------------------------------------------------------------
   function automatic logic [1:0] ratio(input logic byp, input logic sel, input logic rate);
      if (byp)
         ratio = RATIO_BYP;
      else if (sel)
         ratio = rate ? RATIO_24 : RATIO_8;
      else
         ratio = rate ? RATIO_8 : RATIO_8_3;
   endfunction

   // Source and ratios registered for the analog side
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_src_q   <= SRC_TX_REF;
         tx_ratio_q <= RATIO_8_3;
         rx_ratio_q <= RATIO_8_3;
      end else begin
         if (!loop_timing_q)
            tx_src_q <= SRC_TX_REF; // see RL3
         else
            tx_src_q <= cdr_active_in ? SRC_RECOV : SRC_RX_REF; // see RL4
         // Bypass pins mask the select bits
         tx_ratio_q <= ratio(tx_bypass_pin, tx_sel_q, line_rate_select_pin); // see RL7 see RL8 see RL9
         rx_ratio_q <= ratio(rx_bypass_pin, rx_sel_q, line_rate_select_pin); // see RL12 see RL13
      end
   end

   //------------------------------------------------------------
   // Lock monitors
   //------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         quiet_q  <= '0;
         tx_ool_q <= 1'b0;
         rx_ool_q <= 1'b0;
      end else begin
         if (rx_data_edge_in)
            quiet_q <= '0;
         else if (rx_bit_tick_in && quiet_q != 7'(QUIET_BITS))
            quiet_q <= quiet_q + 7'h01;
         tx_ool_q <= tx_freq_off_in; // see RL5
         rx_ool_q <= rx_freq_off_in | (quiet_q == 7'(QUIET_BITS)); // see RL10
      end
   end

   //------------------------------------------------------------
   // Frame loss tracker
   //------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ST_INF: if (frame_slip_in) st_d = ST_OOF;
         ST_OOF: begin
            if (!frame_slip_in)                  st_d = ST_INF;
            else if (cnt_q == CW'(LOF_COUNT))   st_d = ST_LOF; // see RL21
         end
         ST_LOF: if (!frame_slip_in) st_d = ST_REC;
         ST_REC: begin
            if (frame_slip_in)                   st_d = ST_LOF;
            else if (cnt_q == CW'(LOF_COUNT))   st_d = ST_INF; // see RL21
         end
      endcase
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) st_q <= ST_INF;
      else     st_q <= st_d;
   end

   // Timer restarts on every state change
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         cnt_q <= '0;
      else if (st_d != st_q)
         cnt_q <= '0;
      else if (cnt_q != CW'(LOF_COUNT))
         cnt_q <= cnt_q + CW'(1);
   end

   assign lof = (st_q == ST_LOF) | (st_q == ST_REC);

   // Live alarm states
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         los_q  <= 1'b0;
         lof_q  <= 1'b0;
         slip_q <= 1'b0;
      end else begin
         los_q  <= signal_loss_in; // see RL20
         lof_q  <= lof;
         slip_q <= frame_slip_in;
      end
   end

   //------------------------------------------------------------
   // Sticky events, set beats read clear
   //------------------------------------------------------------
   assign ev_set[EV_SLIP] = frame_slip_in != slip_q; // see RL19
   assign ev_set[EV_LOF]  = lof != lof_q;
   assign ev_set[EV_LOS]  = signal_loss_in != los_q;
   assign ev_set[EV_PAR]  = section_parity_err_in; // see RL18
   assign ev_set[EV_TX]   = tx_freq_off_in != tx_ool_q;
   assign ev_set[EV_RX]   = (rx_freq_off_in | (quiet_q == 7'(QUIET_BITS))) != rx_ool_q;
   assign ev_clr[EV_PAR:EV_SLIP] = {4{rd && idx == IDX_RSO_STAT}};
   assign ev_clr[EV_TX]  = rd && idx == IDX_TX_SYNTH;
   assign ev_clr[EV_RX]  = rd && idx == IDX_RX_SYNTH;

   generate
      for (genvar i = 0; i < NUM_EV; i++) begin : g_ev
         // One sticky flag per event
         always_ff @(posedge clk or posedge rst) begin
            if (rst)            ev_q[i] <= 1'b0;
            else if (ev_set[i]) ev_q[i] <= 1'b1;
            else if (ev_clr[i]) ev_q[i] <= 1'b0;
         end
      end
   endgenerate

   // Interrupt low while any enabled event is pending
   always_ff @(posedge clk or posedge rst) begin
      if (rst) irq_n_q <= 1'b1;
      else     irq_n_q <= ~|(ev_q & en_q); // see RL6 see RL11 see RL16 see RL17 see RL22
   end

   //------------------------------------------------------------
   // Outputs
   //------------------------------------------------------------
   assign wb_ack_o             = ack_q;
   assign wb_dat_o             = dat_q;
   assign diag_loopback_enable = diag_q; // see RL1
   assign line_loopback_enable = line_q;
   assign tx_clk_source        = tx_src_q;
   assign tx_pll_ratio         = tx_ratio_q;
   assign rx_div_ratio         = rx_ratio_q;
   assign descramble_disable   = descr_q;
   assign force_frame_loss     = force_q;
   assign interrupt_out_n      = irq_n_q;

   //------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------
   sequence s_force_wr;
      wr && idx == IDX_RSO_CTRL && wb_dat_i[B_FORCE];
   endsequence
   sequence s_bound;
      !frame_boundary_in ##1 frame_boundary_in;
   endsequence

   a_force_at_boundary: assert property (@(posedge clk) disable iff (rst) // see RL15
      s_force_wr ##0 s_bound |=> force_frame_loss)
      else $error("force not issued at boundary");
   a_force_only_pend: assert property (@(posedge clk) disable iff (rst) // see RL15
      force_frame_loss |-> $past(force_pend_q) && $past(frame_boundary_in))
      else $error("force without pending write");
   a_ack_single: assert property (@(posedge clk) disable iff (rst)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
   a_tx_source: assert property (@(posedge clk) disable iff (rst) // see RL4
      loop_timing_q && cdr_active_in |=> tx_clk_source == SRC_RECOV)
      else $error("loop timing source wrong");
   a_tx_bypass: assert property (@(posedge clk) disable iff (rst) // see RL9
      tx_bypass_pin |=> tx_pll_ratio == RATIO_BYP)
      else $error("bypass ratio wrong");
   a_rx_ratio: assert property (@(posedge clk) disable iff (rst) // see RL12
      !rx_bypass_pin && rx_sel_q && line_rate_select_pin |=> rx_div_ratio == RATIO_24)
      else $error("receive divider wrong");
   a_event_sticks: assert property (@(posedge clk) disable iff (rst) // see RL18
      section_parity_err_in |=> ev_q[EV_PAR] ##1 (ev_q[EV_PAR] || $past(ev_clr[EV_PAR])))
      else $error("parity event lost");
   a_irq_follows: assert property (@(posedge clk) disable iff (rst) // see RL16
      en_q[EV_PAR] && section_parity_err_in |=> ##1 !interrupt_out_n)
      else $error("interrupt not asserted");
   a_quiet_lock: assert property (@(posedge clk) disable iff (rst) // see RL10
      quiet_q == 7'(QUIET_BITS) |=> rx_ool_q)
      else $error("quiet line not out of lock");
   a_lof_timer: assert property (@(posedge clk) disable iff (rst) // see RL21
      $rose(lof) |-> $past(st_q) == ST_OOF && $past(cnt_q) == CW'(LOF_COUNT) && $past(frame_slip_in))
      else $error("frame loss declared early");
endmodule

/* sonet_clock_and_section_alarm_regs_tb.sv */
// Self-checking testbench of the SONET clock and section alarm register bank
module sonet_clock_and_section_alarm_regs_tb import scs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   //------------------------------------------------------------
   // Signals
   //------------------------------------------------------------
   localparam int LOF_SIM = 20;      // Shortened frame loss time
   logic        clk = 1'b0;          // Bench clock
   logic        rst = 1'b1;          // Reset, active high
   logic        cyc = 1'b0;          // Bus cycle
   logic        stb = 1'b0;          // Bus strobe
   logic        we = 1'b0;           // Bus direction
   logic [7:0]  adr = 8'h00;         // Byte address
   logic [3:0]  sel = 4'h0;          // Byte selects
   logic [31:0] wdat = 32'h0;        // Write data
   logic [31:0] rdat;                // Read data
   logic        ack;                 // Bus answer
   logic        tx_byp = 1'b0;       // Transmit bypass pin
   logic        rx_byp = 1'b0;       // Receive bypass pin
   logic        rate = 1'b0;         // Line rate pin
   logic        cdr = 1'b0;          // Clock recovery active
   logic        tx_off = 1'b0;       // Transmit comparator
   logic        rx_off = 1'b0;       // Receive comparator
   logic        bit_tick = 1'b0;     // Receive bit period
   logic        data_edge = 1'b0;    // Receive transition
   logic        los = 1'b0;          // Live signal loss
   logic        slip = 1'b0;         // Live out of frame
   logic        par = 1'b0;          // Parity error pulse
   logic        fb = 1'b0;           // Frame boundary pulse
   logic        diag, line, descr, force_o, int_n;
   logic [1:0]  src, txr, rxr;
   int          n_mismatch = 0;      // Failed comparisons
   int          total_checks = 0;    // All comparisons
   always #4 clk = ~clk;
   scs_regs #(.LOF_COUNT(LOF_SIM)) u_dut (
      .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .tx_bypass_pin(tx_byp), .rx_bypass_pin(rx_byp), .line_rate_select_pin(rate),
      .cdr_active_in(cdr), .tx_freq_off_in(tx_off), .rx_freq_off_in(rx_off),
      .rx_bit_tick_in(bit_tick), .rx_data_edge_in(data_edge), .signal_loss_in(los),
      .frame_slip_in(slip), .section_parity_err_in(par), .frame_boundary_in(fb),
      .diag_loopback_enable(diag), .line_loopback_enable(line), .tx_clk_source(src),
      .tx_pll_ratio(txr), .rx_div_ratio(rxr), .descramble_disable(descr),
      .force_frame_loss(force_o), .interrupt_out_n(int_n));
   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   // Closing verdict
   task automatic end_of_test();
      $display("Mismatches %0d, checks %0d", n_mismatch, total_checks);
      if (n_mismatch == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Compare and report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One classic cycle; held until ack is sampled high
   task automatic wb_xfer(input logic w, input logic [5:0] idx, input logic [7:0] d,
                          input logic [3:0] s, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; sel <= s; wdat <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      r = rdat;
      if (n >= 50) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: bus answer missing %h %h", $time, idx, 1);
      end
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      logic [31:0] r;
      wb_xfer(1'b1, idx, d, 4'hf, r);
   endtask
   task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
      logic [31:0] r;
      wb_xfer(1'b0, idx, 8'h00, 4'hf, r);
      chk(r, {24'h0, exp});
   endtask
   // Expected multiplier or divider code
   function automatic logic [1:0] exp_ratio(input logic byp, input logic s, input logic r);
      if (byp) return RATIO_BYP;
      if (!s) return r ? RATIO_8 : RATIO_8_3;
      return r ? RATIO_24 : RATIO_8;
   endfunction
   // Make one alarm event: 0 slip, 1 frame loss, 2 signal loss, 3 parity
   task automatic cause(input int k);
      case (k)
         0: begin slip <= 1'b1; tick(2); slip <= 1'b0; tick(4); end
         1: begin slip <= 1'b1; tick(2 * LOF_SIM); slip <= 1'b0; tick(2 * LOF_SIM); end
         2: begin los <= 1'b1; tick(2); los <= 1'b0; tick(4); end
         default: begin par <= 1'b1; tick(1); par <= 1'b0; tick(4); end
      endcase
   endtask
   //------------------------------------------------------------
   // Watchdog
   //------------------------------------------------------------
   initial begin
      tick(50000);
      n_mismatch++;
      end_of_test();
   end
   //------------------------------------------------------------
   // Main sequence
   //------------------------------------------------------------
   initial begin
      logic [7:0]  d;
      logic [31:0] r;
      int          cnt;
      void'($urandom(32'h918e5a95));
      tick(4);
      rst <= 1'b0;
      // Reset state of outputs and registers
      chk({diag, line, descr, force_o, int_n}, 5'h01);
      foreach (d[i]) begin end
      rd(IDX_LOOP_CTRL, 8'h00); rd(IDX_TX_SYNTH, 8'h00); rd(IDX_RX_SYNTH, 8'h00);
      rd(IDX_RSO_CTRL, 8'h00); rd(IDX_RSO_STAT, 8'h00);
      // Unmapped place and refused byte select
      wr(6'h3f, 8'($urandom)); rd(6'h3f, 8'h00);
      wb_xfer(1'b1, IDX_RSO_CTRL, 8'h4f, 4'he, r); rd(IDX_RSO_CTRL, 8'h00);
      // Loopback and transmit clock source, random settings
      for (int i = 0; i < 12; i++) begin
         d = 8'($urandom);
         if (d[2:1] == 2'b11) d[2] = 1'b0;
         cdr <= 1'($urandom);
         wr(IDX_LOOP_CTRL, d);
         tick(3);
         chk({diag, line}, {d[1], d[2]});
         chk(src, !d[0] ? SRC_TX_REF : (cdr ? SRC_RECOV : SRC_RX_REF));
         rd(IDX_LOOP_CTRL, d & 8'h07);
      end
      wr(IDX_LOOP_CTRL, 8'h00);
      // Reference select against bypass and rate pins
      for (int i = 0; i < 8; i++) begin
         tx_byp <= i[2]; rx_byp <= i[2]; rate <= i[0];
         wr(IDX_TX_SYNTH, {7'h0, i[1]}); wr(IDX_RX_SYNTH, {7'h0, i[1]});
         tick(3);
         chk(txr, exp_ratio(i[2], i[1], i[0]));
         chk(rxr, exp_ratio(i[2], i[1], i[0]));
      end
      wr(IDX_TX_SYNTH, 8'h00);
      wr(IDX_RX_SYNTH, 8'h00);
      // Descramble bypass, write-only force bit and its frame-boundary pulse
      wr(IDX_RSO_CTRL, 8'h60);
      tick(2);
      chk(descr, 1'b1);
      rd(IDX_RSO_CTRL, 8'h40);
      cnt = 0;
      repeat (5) begin @(posedge clk); if (force_o === 1'b1) cnt++; end
      chk(cnt, 0);
      fb <= 1'b1; @(posedge clk); fb <= 1'b0;
      repeat (6) begin @(posedge clk); if (force_o === 1'b1) cnt++; end
      chk(cnt, 1);
      wr(IDX_RSO_CTRL, 8'h20);
      fb <= 1'b1; @(posedge clk); fb <= 1'b0;
      @(posedge clk);
      chk(force_o, 1'b1);
      wr(IDX_RSO_CTRL, 8'h00);
      fb <= 1'b1; @(posedge clk); fb <= 1'b0; cnt = 0;
      repeat (6) begin @(posedge clk); if (force_o === 1'b1) cnt++; end
      chk({cnt[7:0], descr}, 9'h000);
      // Lock status and lock interrupts, transmit then receive
      for (int j = 0; j < 2; j++) begin
         if (j == 0) tx_off <= 1'b1; else rx_off <= 1'b1;
         tick(4);
         chk(int_n, 1'b1);
         rd(6'(IDX_TX_SYNTH + j), 8'h08);
         if (j == 0) tx_off <= 1'b0; else rx_off <= 1'b0;
         tick(4);
         rd(6'(IDX_TX_SYNTH + j), 8'h00);
         wr(6'(IDX_TX_SYNTH + j), 8'h02);
         if (j == 0) tx_off <= 1'b1; else rx_off <= 1'b1;
         tick(4);
         chk(int_n, 1'b0);
         rd(6'(IDX_TX_SYNTH + j), 8'h0a);
         tick(3);
         chk(int_n, 1'b1);
         if (j == 0) tx_off <= 1'b0; else rx_off <= 1'b0;
         tick(4);
         wr(6'(IDX_TX_SYNTH + j), 8'h00);
         rd(6'(IDX_TX_SYNTH + j), 8'h00);
      end
      // Receive quiet line: no transition for more than 80 bit periods
      for (int i = 0; i < QUIET_BITS + 4; i++) begin
         bit_tick <= 1'b1; tick(1); bit_tick <= 1'b0; tick(1);
      end
      rd(IDX_RX_SYNTH, 8'h08);
      data_edge <= 1'b1; tick(1); data_edge <= 1'b0; tick(3);
      rd(IDX_RX_SYNTH, 8'h00);
      // Section status flags and clear on read
      cause(3);
      rd(IDX_RSO_STAT, 8'h40);
      rd(IDX_RSO_STAT, 8'h00);
      los <= 1'b1; tick(3);
      rd(IDX_RSO_STAT, 8'h24);
      rd(IDX_RSO_STAT, 8'h04);
      los <= 1'b0; tick(3);
      rd(IDX_RSO_STAT, 8'h20);
      slip <= 1'b1; tick(LOF_SIM / 2);
      rd(IDX_RSO_STAT, 8'h09);
      tick(2 * LOF_SIM);
      rd(IDX_RSO_STAT, 8'h13);
      slip <= 1'b0; tick(LOF_SIM / 2);
      rd(IDX_RSO_STAT, 8'h0a);
      tick(2 * LOF_SIM);
      rd(IDX_RSO_STAT, 8'h10);
      // Alarm interrupts: masked first, then one enable at a time
      for (int k = 0; k < 4; k++) cause(k);
      chk(int_n, 1'b1);
      rd(IDX_RSO_STAT, 8'h78);
      for (int k = 0; k < 4; k++) begin
         wr(IDX_RSO_CTRL, 8'(1 << k));
         rd(IDX_RSO_STAT, 8'h00);
         cause(k);
         chk(int_n, 1'b0);
         wb_xfer(1'b0, IDX_RSO_STAT, 8'h00, 4'hf, r);
         tick(3);
         chk(int_n, 1'b1);
      end
      end_of_test();
   end
endmodule
